// ### logic/tlis_sequencer.sv
/*
  Digital part of a tone-activated line isolation sequencer: crystal divider,
  half-second tone discriminator, sample-interval and disconnect timers,
  relay and time-base outputs.
  Assumes the crystal arrives as a square wave on crystal_in and the tone as a
  squared-up digital signal; mask options are the module parameters.
*/
// Overview of operation
// [R1] Tone is judged every half-second window; valid_frequency_out goes high on good window.
// [R2] A good window holds nominal frequency within plus or minus 10 Hz.
// [R3] Valid windows run the sample timer; 4.5 s of continuous tone is required.
// [R4] A bad window clears the sample timer and detection starts afresh.
// [R5] Completed sample interval gives a 125 ms high pulse on interval_valid_out.
// [R6] Disconnect timer enable rising edge starts a 2 Hz timer of 20 seconds.
// [R7] Disconnect timer expiry gives a high pulse on disconnect_timeout_out.
// [R8] All timing comes from the 32,768 Hz crystal through a binary divider.
// [R9] Time base output is the crystal clock or 8 Hz, by option.
// [R10] Frequency detector enable acts on its rising edge only.
// [R11] Disconnect timer enable also stops frequency detection during disconnect.
// [R12] After 4.5 s of valid tone, set relay pulses high for 3.9 ms.
// [R13] Second relay output pulses 3.9 ms at expiry, or stays high for 20 s.
// [R14] In reset-relay option the second relay output pulses at power-up.
// [R15] High external reset returns the whole circuit to its initial state.
// [R16] In level option, disconnect enable sets a latch driving the relay level high.
// [R17] Frequency detector enable clears that latch and returns the circuit to idle.
// [R18] Outside wiring joins interval-valid to disconnect enable, timeout to detector enable.
// [R19] valid_frequency_out drops after any window with tone outside the band.
// [R20] Both timers count synchronously on divided crystal ticks.
`timescale 1ns/1ps
module tlis_sequencer
  import tlis_pkg::*;
#(
  parameter int   NOMINAL_HZ    = tlis_pkg::DEF_NOMINAL_HZ,
  parameter logic RELAY_LEVEL   = 1'b1,
  parameter logic TIMEBASE_FAST = 1'b0
)
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic crystal_in,
  input  wire logic digital_tone_in,
  input  wire logic freq_detector_enable,
  input  wire logic disconnect_timer_enable,
  input  wire logic ext_reset,
  output logic      crystal_out,
  output logic      time_base_out,
  output logic      valid_frequency_out,
  output logic      interval_valid_out,
  output logic      disconnect_timeout_out,
  output logic      set_relay_out,
  output logic      relay_b_out
);

  // ==========================================================
  // accepted edge counts per half-second window
  localparam int BAND_LO = ((NOMINAL_HZ - BAND_HZ) * WINDOW_MS + 999) / 1000;
  localparam int BAND_HI = ((NOMINAL_HZ + BAND_HZ) * WINDOW_MS) / 1000;
  localparam logic [TONE_W-1:0]  CNT_LO    = TONE_W'(BAND_LO);
  localparam logic [TONE_W-1:0]  CNT_HI    = TONE_W'(BAND_HI);
  localparam logic [TONE_W-1:0]  CNT_MAX   = '1;
  localparam logic [WIN_W-1:0]   WIN_LAST  = WIN_W'(WINDOW_TICKS - 1);
  localparam logic [SAMP_W-1:0]  SAMP_LAST = SAMP_W'(SAMPLE_WINDOWS - 1);
  localparam logic [DISC_W-1:0]  DISC_LAST = DISC_W'(DISC_TICKS - 1);
  localparam logic [PULSE_W-1:0] VI_LEN    = PULSE_W'(VI_TICKS);
  localparam logic [PULSE_W-1:0] DTO_LEN   = PULSE_W'(DTO_TICKS);
  localparam logic [PULSE_W-1:0] RLY_LEN   = PULSE_W'(RELAY_TICKS);
  // power-up pulse only exists in the pulse option
  localparam logic [PULSE_W-1:0] RB_INIT   = RELAY_LEVEL ? '0 : RLY_LEN;

  // ==========================================================
  // input synchronisation
  tlis_in_s pins;
  tlis_in_s lvl;
  tlis_in_s rise;

  assign pins = '{ext_reset: ext_reset, crystal: crystal_in, tone: digital_tone_in,
                  freq_en: freq_detector_enable, disc_en: disconnect_timer_enable};

  tlis_sync_edge u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pins  (pins),
    .level (lvl),
    .rise  (rise)
  );

  logic tick;
  logic clr;

  assign tick = rise.crystal;
  assign clr  = lvl.ext_reset;

  // ==========================================================
  // crystal divider and tone edge counter
  logic [DIV_W-1:0]  div;
  logic [TONE_W-1:0] tone_cnt;
  logic [DIV_W-1:0]  next_div;
  logic [TONE_W-1:0] next_tone_cnt;
  logic              win_end;
  logic [TONE_W-1:0] win_total;
  logic              in_band;

  always_comb
  begin
    win_end   = tick && (div[WIN_W-1:0] == WIN_LAST);
    win_total = tone_cnt;
    if (rise.tone && tone_cnt != CNT_MAX)
    begin
      win_total = tone_cnt + TONE_W'(1);
    end
    in_band = (win_total >= CNT_LO) && (win_total <= CNT_HI); // [R2]
    next_div      = div;
    next_tone_cnt = win_total;
    if (clr)
    begin
      next_div      = '0;
      next_tone_cnt = '0;
    end
    else
    begin
      if (tick)
      begin
        next_div = div + DIV_W'(1); // [R8]
      end
      if (win_end)
      begin
        next_tone_cnt = '0; // [R1]
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div      <= '0;
      tone_cnt <= '0;
    end
    else
    begin
      div      <= next_div;
      tone_cnt <= next_tone_cnt;
    end
  end

  // ==========================================================
  // sequencer
  tlis_mode_e         mode;
  logic [SAMP_W-1:0]  samp_cnt;
  logic [DISC_W-1:0]  disc_cnt;
  logic [PULSE_W-1:0] vi_cnt;
  logic [PULSE_W-1:0] dto_cnt;
  logic [PULSE_W-1:0] set_cnt;
  logic [PULSE_W-1:0] rb_cnt;
  logic               vf;
  tlis_mode_e         next_mode;
  logic [SAMP_W-1:0]  next_samp_cnt;
  logic [DISC_W-1:0]  next_disc_cnt;
  logic [PULSE_W-1:0] next_vi_cnt;
  logic [PULSE_W-1:0] next_dto_cnt;
  logic [PULSE_W-1:0] next_set_cnt;
  logic [PULSE_W-1:0] next_rb_cnt;
  logic               next_vf;

  always_comb
  begin
    next_mode     = mode;
    next_samp_cnt = samp_cnt;
    next_disc_cnt = disc_cnt;
    next_vf       = vf;
    next_vi_cnt   = vi_cnt;
    next_dto_cnt  = dto_cnt;
    next_set_cnt  = set_cnt;
    next_rb_cnt   = rb_cnt;
    // pulse widths are counted in crystal ticks, not mclk cycles
    if (tick)
    begin
      if (vi_cnt != '0) next_vi_cnt = vi_cnt - PULSE_W'(1);
      if (dto_cnt != '0) next_dto_cnt = dto_cnt - PULSE_W'(1);
      if (set_cnt != '0) next_set_cnt = set_cnt - PULSE_W'(1);
      if (rb_cnt != '0) next_rb_cnt = rb_cnt - PULSE_W'(1);
    end
    if (clr)
    begin
      next_mode     = ST_DETECT; // [R15]
      next_samp_cnt = '0;
      next_disc_cnt = '0;
      next_vf       = 1'b0;
      next_vi_cnt   = '0;
      next_dto_cnt  = '0;
      next_set_cnt  = '0;
      next_rb_cnt   = RB_INIT; // [R14]
    end
    else if (rise.disc_en)
    begin
      // a new edge restarts a running disconnect period
      next_mode     = ST_DISCONNECT; // [R6] [R11] [R16]
      next_disc_cnt = '0;
      next_samp_cnt = '0;
      next_vf       = 1'b0;
    end
    else if (rise.freq_en)
    begin
      next_mode     = ST_DETECT; // [R10] [R17]
      next_samp_cnt = '0;
      next_disc_cnt = '0;
      next_vf       = 1'b0;
    end
    else
    begin
      unique case (mode)
        ST_DETECT:
        begin
          if (win_end)
          begin
            next_vf = in_band; // [R1] [R19]
            if (!in_band)
            begin
              next_samp_cnt = '0; // [R4]
            end
            else if (samp_cnt == SAMP_LAST)
            begin
              next_samp_cnt = '0; // [R3]
              next_vi_cnt   = VI_LEN; // [R5]
              next_set_cnt  = RLY_LEN; // [R12]
            end
            else
            begin
              next_samp_cnt = samp_cnt + SAMP_W'(1); // [R3] [R20]
            end
          end
        end
        ST_DISCONNECT:
        begin
          // window ends are the 2 Hz ticks
          if (win_end)
          begin
            if (disc_cnt == DISC_LAST)
            begin
              next_mode     = ST_WAIT;
              next_disc_cnt = '0;
              next_dto_cnt  = DTO_LEN; // [R7]
              if (!RELAY_LEVEL)
              begin
                next_rb_cnt = RLY_LEN; // [R13]
              end
            end
            else
            begin
              next_disc_cnt = disc_cnt + DISC_W'(1); // [R6] [R20]
            end
          end
        end
        ST_WAIT:
        begin
          // detection stays off until the detector enable edge returns
          next_vf = 1'b0;
        end
        default:
        begin
          next_mode = ST_DETECT;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode     <= ST_DETECT;
      samp_cnt <= '0;
      disc_cnt <= '0;
      vf       <= 1'b0;
      vi_cnt   <= '0;
      dto_cnt  <= '0;
      set_cnt  <= '0;
      rb_cnt   <= RB_INIT;
    end
    else
    begin
      mode     <= next_mode;
      samp_cnt <= next_samp_cnt;
      disc_cnt <= next_disc_cnt;
      vf       <= next_vf;
      vi_cnt   <= next_vi_cnt;
      dto_cnt  <= next_dto_cnt;
      set_cnt  <= next_set_cnt;
      rb_cnt   <= next_rb_cnt;
    end
  end

  // ==========================================================
  // output flops
  logic next_crystal_out;
  logic next_time_base;
  logic next_rb_out;

  always_comb
  begin
    next_crystal_out = ~lvl.crystal;
    next_time_base   = TIMEBASE_FAST ? lvl.crystal : div[TB_SLOW_BIT]; // [R9]
    next_rb_out      = RELAY_LEVEL ? (next_mode == ST_DISCONNECT) // [R13] [R16]
                                   : (next_rb_cnt != '0);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crystal_out            <= 1'b1;
      time_base_out          <= 1'b0;
      valid_frequency_out    <= 1'b0;
      interval_valid_out     <= 1'b0;
      disconnect_timeout_out <= 1'b0;
      set_relay_out          <= 1'b0;
      relay_b_out            <= 1'b0;
    end
    else
    begin
      crystal_out            <= next_crystal_out;
      time_base_out          <= next_time_base;
      valid_frequency_out    <= next_vf;
      interval_valid_out     <= (next_vi_cnt != '0);
      disconnect_timeout_out <= (next_dto_cnt != '0);
      set_relay_out          <= (next_set_cnt != '0);
      relay_b_out            <= next_rb_out;
    end
  end

endmodule

// ### logic/tlis_pkg.sv
/*
  Shared constants and types of the tone line isolation sequencer.
  Assumes a 20 MHz system clock and a 32,768 Hz crystal square wave on a pin.
*/
package tlis_pkg;

  // ==========================================================
  // crystal time base
  localparam int XTAL_HZ        = 32768;
  localparam int DIV_W          = 15;
  localparam int WINDOW_MS      = 500;
  localparam int WINDOW_TICKS   = XTAL_HZ * WINDOW_MS / 1000;
  localparam int WIN_W          = 14;
  localparam int TB_SLOW_HZ     = 8;
  localparam int TB_SLOW_BIT    = $clog2(XTAL_HZ / TB_SLOW_HZ) - 1;

  // ==========================================================
  // tone discrimination
  localparam int BAND_HZ        = 10;
  localparam int DEF_NOMINAL_HZ = 2713;
  localparam int TONE_W         = 13;

  // ==========================================================
  // sequencing periods
  localparam int SAMPLE_MS      = 4500;
  localparam int SAMPLE_WINDOWS = SAMPLE_MS / WINDOW_MS;
  localparam int SAMP_W         = 4;
  localparam int DISC_MS        = 20000;
  localparam int DISC_TICKS     = DISC_MS / WINDOW_MS;
  localparam int DISC_W         = 6;

  // ==========================================================
  // output pulse widths, in crystal ticks
  localparam int PULSE_W        = 13;
  localparam int VI_PULSE_MS    = 125;
  localparam int VI_TICKS       = XTAL_HZ * VI_PULSE_MS / 1000;
  localparam int DTO_PULSE_MS   = 125;
  localparam int DTO_TICKS      = XTAL_HZ * DTO_PULSE_MS / 1000;
  localparam int RELAY_PULSE_US = 3900;
  localparam int RELAY_TICKS    = (XTAL_HZ * RELAY_PULSE_US + 999999) / 1000000;

  // ==========================================================
  // types
  typedef struct packed {
    logic ext_reset;
    logic crystal;
    logic tone;
    logic freq_en;
    logic disc_en;
  } tlis_in_s;

  localparam int IN_W = $bits(tlis_in_s);

  typedef enum logic [1:0] {
    ST_DETECT,
    ST_DISCONNECT,
    ST_WAIT
  } tlis_mode_e;

endpackage

// ### logic/tlis_sync_edge.sv
/*
  Two-stage synchroniser with rising-edge detect for the pin inputs.
  Assumes inputs are slow against mclk (crystal is the fastest, 32,768 Hz).
*/
`timescale 1ns/1ps
module tlis_sync_edge
  import tlis_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire tlis_pkg::tlis_in_s  pins,
  output tlis_pkg::tlis_in_s       level,
  output tlis_pkg::tlis_in_s       rise
);

  logic [IN_W-1:0] meta;
  logic [IN_W-1:0] stable;
  logic [IN_W-1:0] last;
  logic [IN_W-1:0] next_meta;
  logic [IN_W-1:0] next_stable;
  logic [IN_W-1:0] next_last;

  // ==========================================================
  // stages; only the second and third stages feed any logic
  always_comb
  begin
    next_meta   = pins;
    next_stable = meta;
    next_last   = stable;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta   <= '0;
      stable <= '0;
      last   <= '0;
    end
    else
    begin
      meta   <= next_meta;
      stable <= next_stable;
      last   <= next_last;
    end
  end

  assign level = tlis_in_s'(stable);
  assign rise  = tlis_in_s'(stable & ~last);

endmodule

// ### bench/tlis_sequencer_asserts.sv
/*
  Pin-level checker of the sequencer, bound to tlis_sequencer.
  Assumes the default options: relay level on relay_b_out, 8 Hz time base.
*/
`timescale 1ns/1ps
module tlis_sequencer_asserts
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic crystal_in,
  input wire logic digital_tone_in,
  input wire logic freq_detector_enable,
  input wire logic disconnect_timer_enable,
  input wire logic ext_reset,
  input wire logic crystal_out,
  input wire logic time_base_out,
  input wire logic valid_frequency_out,
  input wire logic interval_valid_out,
  input wire logic disconnect_timeout_out,
  input wire logic set_relay_out,
  input wire logic relay_b_out
);
  // ==========================================================
  // crystal ticks since the last time-base change
  logic [11:0] ticks;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ticks <= 12'h0;
    else if (ext_reset || $changed(time_base_out))
      ticks <= 12'h0;
    else if ($rose(crystal_in))
      ticks <= ticks + 12'h1;
  end

  // ==========================================================
  // properties
  chk_vf_window_end: assert property ($rose(valid_frequency_out) |->
    (!time_base_out && $past(time_base_out, 3)) or (##[0:8] $fell(time_base_out)))
    else $error("valid frequency rose away from a window end");
  // sync slip of one tick either way is tolerated
  chk_tb_half: assert property ($changed(time_base_out) && !ext_reset |->
    ticks inside {[12'h7fe:12'h801]}) else $error("time base half period wrong");
  chk_set_with_iv: assert property ($rose(interval_valid_out) |->
    $rose(set_relay_out)) else $error("set relay not with interval valid");
  chk_level_set: assert property ($rose(disconnect_timer_enable) && !ext_reset
    |-> ##[2:6] relay_b_out) else $error("relay level not raised");
  chk_latch_clear: assert property ($rose(freq_detector_enable)
    && !disconnect_timer_enable && !ext_reset |-> ##[2:6] !relay_b_out)
    else $error("relay level not cleared");
  chk_ext_clear: assert property (ext_reset [*4] |-> ##1 !(valid_frequency_out
    || interval_valid_out || set_relay_out || disconnect_timeout_out || relay_b_out))
    else $error("external reset left an output high");
  chk_no_detect: assert property (relay_b_out |-> !$rose(valid_frequency_out))
    else $error("detection ran during disconnect");
  chk_xtal_feed: assert property ($changed(crystal_in) |-> ##[1:4]
    $changed(crystal_out)) else $error("crystal feedback stuck");
  chk_expiry_drop: assert property ($rose(disconnect_timeout_out) |->
    ##[1:3] !relay_b_out) else $error("relay level held past expiry");

  cover property ($rose(valid_frequency_out));
  cover property ($fell(valid_frequency_out));
  cover property ($rose(relay_b_out));
endmodule

bind tlis_sequencer tlis_sequencer_asserts u_chk (.mclk, .rst_n, .crystal_in,
  .digital_tone_in, .freq_detector_enable, .disconnect_timer_enable, .ext_reset,
  .crystal_out, .time_base_out, .valid_frequency_out, .interval_valid_out,
  .disconnect_timeout_out, .set_relay_out, .relay_b_out);

// ### bench/tlis_line_model.sv
/*
  Far side of the sequencer: crystal, squared line tone and pin wiring.
  Assumes mclk at 20 MHz; the crystal runs at half that rate to keep windows short.
*/
`timescale 1ns/1ps
module tlis_line_model
(
  input  wire logic        mclk,
  input  wire logic [12:0] rate,
  input  wire logic        ivalid,
  input  wire logic        tmo,
  input  wire logic        dis_req,
  input  wire logic        det_req,
  output logic             xtal,
  output logic             tone,
  output logic             dis_en,
  output logic             det_en
);
  // ==========================================================
  // a window is 32768 mclk here, so 2*rate toggles land in each
  logic [15:0] acc;
  logic [15:0] sum;

  assign sum = acc + {2'b00, rate, 1'b0};

  // one process drives every output, so each pin has a single driver
  initial
  begin
    xtal = 1'b0;
    tone = 1'b0;
    acc = 16'h0;
    dis_en = 1'b0;
    det_en = 1'b0;
    forever
    begin
      @(negedge mclk);
      xtal <= ~xtal;
      acc <= {1'b0, sum[14:0]};
      if (sum[15])
        tone <= ~tone;
      dis_en <= ivalid | dis_req;
      det_en <= tmo | det_req;
    end
  end
endmodule

// ### bench/testbench.sv
/*
  Self-checking bench of the tone line isolation sequencer, default options.
  Assumes the line model sets crystal and tone; notes are checked on output changes.
*/
`timescale 1ns/1ps
module testbench;
  import tlis_pkg::*;
  // ==========================================================
  // pins and bookkeeping
  logic        mclk, rst_n, ext_reset, dis_req, det_req;
  logic [12:0] rate;
  logic        crystal_in, digital_tone_in, freq_detector_enable, disconnect_timer_enable;
  logic        crystal_out, time_base_out, valid_frequency_out, interval_valid_out;
  logic        disconnect_timeout_out, set_relay_out, relay_b_out;
  logic        tb_d = 1'b0;
  logic [4:0]  outs, seen;
  logic [4:0]  expq[$];
  int          tbq[$];
  int          tbn = 0;
  int          cyc = 0;
  int          mismatches, checks;
  logic [31:0] seed;

  assign outs = {valid_frequency_out, interval_valid_out, disconnect_timeout_out,
                 set_relay_out, relay_b_out};

  tlis_line_model u_line (
    .mclk    (mclk),
    .rate    (rate),
    .ivalid  (interval_valid_out),
    .tmo     (disconnect_timeout_out),
    .dis_req (dis_req),
    .det_req (det_req),
    .xtal    (crystal_in),
    .tone    (digital_tone_in),
    .dis_en  (disconnect_timer_enable),
    .det_en  (freq_detector_enable)
  );

  tlis_sequencer dut (
    .mclk                    (mclk),
    .rst_n                   (rst_n),
    .crystal_in              (crystal_in),
    .digital_tone_in         (digital_tone_in),
    .freq_detector_enable    (freq_detector_enable),
    .disconnect_timer_enable (disconnect_timer_enable),
    .ext_reset               (ext_reset),
    .crystal_out             (crystal_out),
    .time_base_out           (time_base_out),
    .valid_frequency_out     (valid_frequency_out),
    .interval_valid_out      (interval_valid_out),
    .disconnect_timeout_out  (disconnect_timeout_out),
    .set_relay_out           (set_relay_out),
    .relay_b_out             (relay_b_out)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic check_outs(input logic [4:0] exp, input logic [4:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH outputs expected %b seen %b", exp, got);
    end
  endtask

  task automatic check_int(input string name, input int exp, input int got);
    checks++;
    if (got != exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic summarize();
    check_int("notes left", 0, expq.size());
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // which: 0 disconnect enable, 1 detector enable, 2 external reset
  task automatic hit(input int which);
    dis_req = (which == 0);
    det_req = (which == 1);
    ext_reset = (which == 2);
    repeat (10) @(negedge mclk);
    dis_req = 1'b0;
    det_req = 1'b0;
    ext_reset = 1'b0;
    repeat (20) @(negedge mclk);
  endtask

  task automatic wait_vf(input logic v);
    for (int i = 0; i < 40000 && valid_frequency_out !== v; i++)
      @(negedge mclk);
  endtask

  // ==========================================================
  // clock, monitors and timeout
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // settle two cycles so outputs moving together form one note
  initial
  begin
    seen = 5'h0;
    forever
    begin
      // sampled on the falling edge, where the registered outputs have settled
      @(negedge mclk);
      if (rst_n === 1'b1 && outs !== seen)
      begin
        repeat (2) @(negedge mclk);
        seen = outs;
        if (expq.size() > 0)
          check_outs(expq.pop_front(), seen);
        else
          check_outs(5'hx, seen);
      end
    end
  end

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    tb_d <= time_base_out;
    tbn <= (time_base_out !== tb_d) ? 1 : tbn + 1;
    if (time_base_out !== tb_d && tbq.size() > 0)
      check_int("time base half period", tbq.pop_front(), tbn);
    // a clean run ends near 98,600 cycles
    if (cyc == 100000)
    begin
      mismatches++;
      summarize();
    end
  end

  // ==========================================================
  // stimulus
  initial
  begin
    seed = xs(32'hcac0358d);
    rate = 13'(DEF_NOMINAL_HZ / 2 - 2 + seed % 5);
    {rst_n, ext_reset, dis_req, det_req} = 4'h0;
    mismatches = 0;
    checks = 0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 9000 && time_base_out !== 1'b1; i++)
      @(negedge mclk);
    repeat (2) @(negedge mclk);
    tbq.push_back(XTAL_HZ / TB_SLOW_HZ);
    expq.push_back(5'b10000);
    wait_vf(1'b1);
    $display("test good window done");
    seed = xs(seed);
    rate = 13'((DEF_NOMINAL_HZ + BAND_HZ) / 2 + 3 + seed % 30);
    expq.push_back(5'b00000);
    wait_vf(1'b0);
    $display("test bad window done");
    seed = xs(seed);
    rate = 13'(DEF_NOMINAL_HZ / 2 - 2 + seed % 5);
    expq.push_back(5'b00001);
    hit(0);
    // a whole good window (32768 cycles here) passes while detection is held off
    repeat (32900) @(negedge mclk);
    $display("test held detection done");
    expq.push_back(5'b00000);
    hit(1);
    expq.push_back(5'b00001);
    hit(0);
    expq.push_back(5'b00000);
    hit(2);
    $display("test enables and reset done");
    summarize();
  end
endmodule
